// [design/fbep_mem.sv]
// Flash word array with registered read data
`timescale 1ns/100ps
`default_nettype none
module fbep_mem #(
   parameter int AW = 15,
   parameter int DW = 32
) (
   input  wire logic          mclk,
   input  wire logic          memRe,
   input  wire logic          memWe,
   input  wire logic [AW-1:0] memAddr,
   input  wire logic [DW-1:0] memWdata,
   output logic      [DW-1:0] memRdata
);
   logic [DW-1:0] store [0:(2**AW)-1];

   always_ff @(posedge mclk) begin
      if (memWe) begin
         store[memAddr] <= memWdata;
      end
   end

   // Zero unless read, so a refused read never shows stale contents
   always_ff @(posedge mclk) begin
      memRdata <= memRe ? store[memAddr] : '0;
   end
endmodule
`default_nettype wire

// [design/fbep_top.sv]
// Flash access, block erase and protection control
`timescale 1ns/100ps
`default_nettype none
`include "fbep_consts.svh"

// Contract
// - 128 KB array in 1 KB blocks, each erased alone.
// - Finished erase leaves every bit of the block at one.
// - Protection is per 2 KB unit of two adjacent blocks.
// - Each unit may be set read-only or execute-only.
// - Read-only units refuse erase and program; contents stay.
// - Execute-only units refuse erase and program too.
// - Execute-only units answer only instruction fetch reads.
// - Permitted reads answer in one clock, no wait states.
module fbep_top (
   input  wire logic                       mclk,
   input  wire logic                       rst,
   input  wire logic                       reqValid,
   input  wire fbep_pkg::fbep_op_t         reqOp,
   input  wire fbep_pkg::fbep_src_t        reqSrc,
   input  wire logic [`FBEP_ADDR_W-1:0]    reqAddr,
   input  wire logic [`FBEP_DATA_W-1:0]    reqWdata,
   input  wire logic                       protWe,
   input  wire logic [`FBEP_UNIT_W-1:0]    protUnit,
   input  wire logic                       protReadOnly,
   input  wire logic                       protExecOnly,
   input  wire logic                       violClr,
   output logic                            reqReady,
   output logic                            rspValid,
   output logic                            rspDenied,
   output logic [`FBEP_DATA_W-1:0]         rspData,
   output logic                            violation
);
   localparam int WAW = `FBEP_ADDR_W - `FBEP_WORD_LSB;

   function automatic logic [`FBEP_UNIT_W-1:0] unitOf(input logic [`FBEP_ADDR_W-1:0] a);
      unitOf = a[`FBEP_ADDR_W-1:`FBEP_UNIT_LSB];
   endfunction

   fbep_pkg::fbep_state_t           state;
   fbep_pkg::fbep_state_t           next_state;
   logic [`FBEP_UNITS-1:0]          roBits;
   logic [`FBEP_UNITS-1:0]          xoBits;
   logic [`FBEP_BLK_W-1:0]          eraseBlk;
   logic [`FBEP_CNT_W-1:0]          eraseCnt;

   // Nothing is taken while reset is held
   wire                     accept    = reqValid & reqReady & ~rst;
   wire [`FBEP_UNIT_W-1:0]  unitSel   = unitOf(reqAddr);
   wire                     unitRo    = roBits[unitSel];
   wire                     unitXo    = xoBits[unitSel];
   wire                     isRead    = (reqOp == fbep_pkg::FBEP_OP_READ);
   wire                     isProg    = (reqOp == fbep_pkg::FBEP_OP_PROG);
   wire                     isErase   = (reqOp == fbep_pkg::FBEP_OP_ERASE);
   wire                     isFetch   = (reqSrc == fbep_pkg::FBEP_SRC_FETCH);
   // Modify refused on any protected unit, read refused on execute-only unless fetch
   wire                     denyMod   = (isProg | isErase)
                                      & (unitRo | unitXo);
   wire                     denyRead  = isRead & unitXo & ~isFetch;
   wire                     denyNow   = accept & (denyMod | denyRead);
   wire                     okRead    = accept & isRead & ~denyRead;
   wire                     okProg    = accept & isProg & ~denyMod;
   wire                     okErase   = accept & isErase & ~denyMod;
   wire                     erasing   = (state == fbep_pkg::FBEP_ST_ERASE);
   wire                     eraseLast = erasing & (eraseCnt == `FBEP_LAST_WORD);

   // Array port: erase sweep owns it while erasing
   wire             memWe    = erasing | okProg;
   wire             memRe    = okRead;
   wire [WAW-1:0]   memAddr  = erasing ? {eraseBlk, eraseCnt}
                                       : reqAddr[`FBEP_ADDR_W-1:`FBEP_WORD_LSB];
   wire [`FBEP_DATA_W-1:0] memWdata = erasing ? `FBEP_ERASED : reqWdata;

   fbep_mem #(
      .AW (WAW),
      .DW (`FBEP_DATA_W)
   ) u_mem (
      .mclk     (mclk),
      .memRe    (memRe),
      .memWe    (memWe),
      .memAddr  (memAddr),
      .memWdata (memWdata),
      .memRdata (rspData)
   );

   // Idle until a permitted erase, back once the last word is written
   always_comb begin
      next_state = state;
      unique case (state)
         fbep_pkg::FBEP_ST_IDLE: begin
            if (okErase) begin
               next_state = fbep_pkg::FBEP_ST_ERASE;
            end
         end
         fbep_pkg::FBEP_ST_ERASE: begin
            if (eraseLast) begin
               next_state = fbep_pkg::FBEP_ST_IDLE;
            end
         end
      endcase
   end

   // Sweep counter walks every word of the chosen block
   always_ff @(posedge mclk) begin
      if (rst) begin
         state    <= fbep_pkg::FBEP_ST_IDLE;
         eraseBlk <= '0;
         eraseCnt <= '0;
      end else begin
         state <= next_state;
         if (okErase) begin
            eraseBlk <= reqAddr[`FBEP_ADDR_W-1:`FBEP_BLK_LSB];
            eraseCnt <= '0;
         end else if (erasing) begin
            eraseCnt <= eraseCnt + 1'h1;
         end
      end
   end

   // Protection settings per 2 KB unit
   always_ff @(posedge mclk) begin
      if (rst) begin
         roBits <= '0;
         xoBits <= '0;
      end else if (protWe) begin
         roBits[protUnit] <= protReadOnly;
         xoBits[protUnit] <= protExecOnly;
      end
   end

   // One answer per accepted request; a permitted erase answers when its sweep ends
   always_ff @(posedge mclk) begin
      if (rst) begin
         reqReady  <= 1'h1;
         rspValid  <= 1'h0;
         rspDenied <= 1'h0;
      end else begin
         reqReady  <= erasing ? eraseLast : ~okErase;
         rspValid  <= (accept & ~okErase) | eraseLast;
         rspDenied <= denyNow;
      end
   end

   // Set wins over clear
   always_ff @(posedge mclk) begin
      if (rst) begin
         violation <= 1'h0;
      end else begin
         violation <= denyNow | (violation & ~violClr);
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // Erase sweep
   a_erase_ones: assert property (
      erasing |-> memWe && memWdata == `FBEP_ERASED)
      else $error("erase sweep not writing all ones");

   a_erase_block: assert property (
      erasing |-> memAddr[WAW-1:`FBEP_CNT_W] == eraseBlk)
      else $error("erase sweep left its block");

   a_erase_length: assert property (
      okErase |=> !reqReady ##255 !reqReady ##1 rspValid && reqReady)
      else $error("erase did not finish after 256 words");

   a_erase_closed: assert property (
      erasing |-> !reqReady && !accept)
      else $error("request port open during erase sweep");

   a_erase_exit: assert property (
      eraseLast |=> !erasing && reqReady && rspValid && !rspDenied)
      else $error("erase sweep did not close cleanly");

   // Protection
   a_ro_refuse: assert property (
      accept && !isRead && unitRo |-> !memWe ##1 rspDenied && violation)
      else $error("read-only unit accepted a modify");

   a_xo_refuse: assert property (
      accept && !isRead && unitXo |=> rspDenied && state == fbep_pkg::FBEP_ST_IDLE)
      else $error("execute-only unit accepted a modify");

   a_xo_data_read: assert property (
      accept && isRead && unitXo && !isFetch
         |=> rspValid && rspDenied && rspData == `FBEP_ZERO_DATA)
      else $error("execute-only contents leaked to a non-fetch read");

   a_xo_fetch_read: assert property (
      accept && isRead && unitXo && isFetch |=> rspValid && !rspDenied)
      else $error("execute-only unit refused an instruction fetch");

   a_open_accept: assert property (
      accept && !unitRo && !unitXo |=> !rspDenied && !$rose(violation))
      else $error("unprotected unit refused a request");

   a_prog_write: assert property (
      okProg |-> memWe && memWdata == reqWdata
         && memAddr == reqAddr[`FBEP_ADDR_W-1:`FBEP_WORD_LSB])
      else $error("permitted program did not reach its word");

   // Response timing and data
   a_read_latency: assert property (
      okRead |=> rspValid && !rspDenied && reqReady)
      else $error("permitted read not answered in one cycle");

   a_quiet_data: assert property (
      !okRead |=> rspData == `FBEP_ZERO_DATA)
      else $error("array contents shown without a permitted read");

   // Refused writes and violation flag
   a_deny_no_write: assert property (
      denyNow |-> !memWe)
      else $error("refused request wrote the array");

   a_viol_sticky: assert property (
      violation && !violClr && !denyNow |=> violation)
      else $error("violation flag dropped without a clear");

   a_viol_set_wins: assert property (
      denyNow && violClr |=> violation)
      else $error("clear beat a new violation");

   a_viol_clear: assert property (
      violClr && !denyNow |=> !violation)
      else $error("violation flag survived a clear");
endmodule
`default_nettype wire

// [inc/fbep_consts.svh]
// Constants for the flash erase and protection block
`ifndef FBEP_CONSTS_SVH
`define FBEP_CONSTS_SVH
`define FBEP_ADDR_W      17
`define FBEP_DATA_W      32
`define FBEP_WORD_LSB    2
`define FBEP_BLK_LSB     10
`define FBEP_UNIT_LSB    11
`define FBEP_UNIT_W      6
`define FBEP_BLK_W       7
`define FBEP_CNT_W       8
`define FBEP_UNITS       64
`define FBEP_LAST_WORD   8'hff
`define FBEP_ERASED      32'hffffffff
`define FBEP_ZERO_DATA   32'h00000000
`define FBEP_ERASE_LAT   256
`endif

// [inc/fbep_pkg.sv]
// Types for the flash erase and protection block
`default_nettype none
package fbep_pkg;
   typedef enum logic [1:0] {
      FBEP_OP_READ  = 2'b00,
      FBEP_OP_PROG  = 2'b01,
      FBEP_OP_ERASE = 2'b10
   } fbep_op_t;
   typedef enum logic [1:0] {
      FBEP_SRC_FETCH = 2'b00,
      FBEP_SRC_DATA  = 2'b01,
      FBEP_SRC_DEBUG = 2'b10
   } fbep_src_t;
   typedef enum logic {
      FBEP_ST_IDLE  = 1'b0,
      FBEP_ST_ERASE = 1'b1
   } fbep_state_t;
endpackage
`default_nettype wire

// [test/fbep_req_model.sv]
// Requester model: core fetch, core data and debugger paths
`timescale 1ns/100ps
`default_nettype none
`include "fbep_consts.svh"
module fbep_req_model (
   input  wire logic                   mclk,
   input  wire logic                   reqReady,
   output var  logic                   reqValid,
   output var  fbep_pkg::fbep_op_t     reqOp,
   output var  fbep_pkg::fbep_src_t    reqSrc,
   output var  logic [`FBEP_ADDR_W-1:0] reqAddr,
   output var  logic [`FBEP_DATA_W-1:0] reqWdata
);
   initial begin
      reqValid = 1'h0;
      reqOp = fbep_pkg::FBEP_OP_READ;
      reqSrc = fbep_pkg::FBEP_SRC_FETCH;
      reqAddr = 17'h0;
      reqWdata = 32'h0;
   end
   // Hold until taken, then drop valid and invert reqAddr and reqWdata
   task automatic send(input fbep_pkg::fbep_op_t op, input fbep_pkg::fbep_src_t src,
         input logic [16:0] a, input logic [31:0] d);
      @(negedge mclk);
      reqValid = 1'h1;
      reqOp = op;
      reqSrc = src;
      reqAddr = a;
      reqWdata = d;
      @(posedge mclk);
      while (reqReady !== 1'h1) @(posedge mclk);
      @(negedge mclk);
      reqValid = 1'h0;
      reqAddr = ~reqAddr;
      reqWdata = ~reqWdata;
   endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for flash access, erase and protection
`timescale 1ns/100ps
`default_nettype none
`include "fbep_consts.svh"
module tb_top;
   localparam logic [1:0] RD = 2'h0, PG = 2'h1, ER = 2'h2, FE = 2'h0, DA = 2'h1, DB = 2'h2;
   logic        mclk = 1'h0;
   logic        rst = 1'h1;
   logic        protWe = 1'h0, protRo = 1'h0, protXo = 1'h0, violClr = 1'h0;
   logic [5:0]  protUnit = 6'h0;
   logic        reqValid, reqReady, rspValid, rspDenied, violation;
   logic [16:0] reqAddr;
   logic [31:0] reqWdata, rspData;
   fbep_pkg::fbep_op_t  reqOp;
   fbep_pkg::fbep_src_t reqSrc;
   int          n_mismatch = 0;
   int          n_checks = 0;
   always #2.5 mclk = ~mclk;
   fbep_req_model req_u (.mclk(mclk), .reqReady(reqReady), .reqValid(reqValid),
      .reqOp(reqOp), .reqSrc(reqSrc), .reqAddr(reqAddr), .reqWdata(reqWdata));
   fbep_top dut_u (.mclk(mclk), .rst(rst), .reqValid(reqValid), .reqOp(reqOp),
      .reqSrc(reqSrc), .reqAddr(reqAddr), .reqWdata(reqWdata), .protWe(protWe),
      .protUnit(protUnit), .protReadOnly(protRo), .protExecOnly(protXo),
      .violClr(violClr), .reqReady(reqReady), .rspValid(rspValid),
      .rspDenied(rspDenied), .rspData(rspData), .violation(violation));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // One request, answer timed from the acceptance edge
   task automatic xf(input logic [1:0] op, input logic [1:0] src, input logic [16:0] a,
         input logic [31:0] d, input logic den, input logic [31:0] ed, input int lat);
      int n;
      n = 1;
      req_u.send(fbep_pkg::fbep_op_t'(op), fbep_pkg::fbep_src_t'(src), a, d);
      while (rspValid !== 1'h1 && n < 300) begin
         @(negedge mclk);
         n++;
      end
      chk("latency", lat, n);
      chk("rspDenied", den, rspDenied);
      chk("rspData", ed, rspData);
      if (den) begin
         @(negedge mclk);
         chk("violation", 32'h1, violation);
         violClr = 1'h1;
         @(negedge mclk);
         violClr = 1'h0;
         chk("violClr", 32'h0, violation);
      end
   endtask
   task automatic prot(input logic [5:0] u, input logic ro, input logic xo);
      @(negedge mclk);
      protWe = 1'h1;
      protUnit = u;
      protRo = ro;
      protXo = xo;
      @(negedge mclk);
      protWe = 1'h0;
   endtask
   task automatic t_open();
      xf(PG, DA, 17'h00010, 32'h5a5a0001, 1'h0, 32'h0, 1);
      for (int s = 0; s < 3; s++)
         xf(RD, s[1:0], 17'h00010, 32'h0, 1'h0, 32'h5a5a0001, 1);
      $display("t_open done");
   endtask
   task automatic t_erase();
      xf(PG, DA, 17'h00bfc, 32'h1234abcd, 1'h0, 32'h0, 1);
      xf(PG, DA, 17'h00c00, 32'h0badf00d, 1'h0, 32'h0, 1);
      xf(ER, DB, 17'h00a00, 32'h0, 1'h0, 32'h0, 257);
      xf(RD, DA, 17'h00800, 32'h0, 1'h0, `FBEP_ERASED, 1);
      xf(RD, DA, 17'h00bfc, 32'h0, 1'h0, `FBEP_ERASED, 1);
      xf(RD, DA, 17'h00c00, 32'h0, 1'h0, 32'h0badf00d, 1);
      $display("t_erase done");
   endtask
   task automatic t_ro();
      prot(6'h01, 1'h1, 1'h0);
      xf(PG, DA, 17'h00c00, 32'h0, 1'h1, 32'h0, 1);
      xf(ER, FE, 17'h00c00, 32'h0, 1'h1, 32'h0, 1);
      xf(RD, DB, 17'h00c00, 32'h0, 1'h0, 32'h0badf00d, 1);
      xf(PG, DA, 17'h007fc, 32'h77, 1'h0, 32'h0, 1);
      xf(RD, DA, 17'h007fc, 32'h0, 1'h0, 32'h77, 1);
      $display("t_ro done");
   endtask
   task automatic t_xo();
      xf(PG, DA, 17'h1fffc, 32'hc0de0001, 1'h0, 32'h0, 1);
      prot(6'h3f, 1'h0, 1'h1);
      xf(RD, FE, 17'h1fffc, 32'h0, 1'h0, 32'hc0de0001, 1);
      xf(RD, DA, 17'h1fffc, 32'h0, 1'h1, 32'h0, 1);
      xf(RD, DB, 17'h1fffc, 32'h0, 1'h1, 32'h0, 1);
      xf(PG, FE, 17'h1fffc, 32'h0, 1'h1, 32'h0, 1);
      xf(ER, DA, 17'h1f800, 32'h0, 1'h1, 32'h0, 1);
      xf(RD, FE, 17'h1fffc, 32'h0, 1'h0, 32'hc0de0001, 1);
      $display("t_xo done");
   endtask
   initial begin
      repeat (10) @(negedge mclk);
      rst = 1'h0;
      chk("reqReady", 32'h1, reqReady);
      t_open();
      t_erase();
      t_ro();
      t_xo();
      give_verdict();
   end
   // Tests need about 330 cycles; allow 3000
   initial begin
      #15000;
      n_mismatch++;
      give_verdict();
   end
endmodule
`default_nettype wire
